// ### shared/afc_map.svh
// register map, field positions, reset values and timing counts
`ifndef AFC_MAP_SVH
`define AFC_MAP_SVH

`define AFC_IDX_W 10
`define AFC_IDX_PWR_FOUR 10'h00b
`define AFC_IDX_CLK_ONE 10'h028
`define AFC_IDX_CLK_TWO 10'h029
`define AFC_IDX_DAC_RATE 10'h035
`define AFC_IDX_ADC_RATE 10'h046
`define AFC_IDX_DAC_IF 10'h073
`define AFC_IDX_STATUS 10'h07f

`define AFC_BIT_SLOW_EN_PWR 8
`define AFC_BIT_SLOW_EN_CLK 15
`define AFC_BIT_SLOW_RATE 14
`define AFC_BCLK_DIV_MSB 7
`define AFC_BCLK_DIV_LSB 4
`define AFC_OUT_DIV_MSB 2
`define AFC_BIT_FRAME_SEL 15
`define AFC_BIT_FRAME_EN 11
`define AFC_LEN_MSB 10
`define AFC_BIT_BIT_CLOCK_MASTER_ENABLE 14

`define AFC_LEN_RST 11'h040
`define AFC_BCLK_DIV_RST 4'h0
`define AFC_OUT_DIV_RST 3'h0

`define AFC_SLOW_LOG_SLOW 21
`define AFC_SLOW_LOG_FAST 19
`define AFC_AGE_MAX 4'hf

`endif

// ### shared/afc_pkg.sv
// types shared by the frame and aux clock generator
package afc_pkg;
  typedef logic [10:0] afc_len_t;
  typedef logic [6:0] afc_half_div_t;
  typedef logic [31:0] afc_word_t;
  typedef enum logic {AFC_CH_ADC = 1'b0, AFC_CH_DAC = 1'b1} afc_chan_t;
endpackage

// ### shared/afc_div_if.sv
// link between the control logic and a half-step clock divider
`timescale 1ns/1ps
interface afc_div_if;
  logic enable;
  afc_pkg::afc_half_div_t half_div;
  logic tick;
  logic level;
  modport ctl (output enable, output half_div, input tick, input level);
  modport div (input enable, input half_div, output tick, output level);
endinterface

// ### core/afc_frac_div.sv
// divider by a whole or half ratio of the system clock
`timescale 1ns/1ps
`include "afc_map.svh"
module afc_frac_div (
  input wire logic clk_in,
  input wire logic rst_n_in,
  afc_div_if.div div_if
);
  import afc_pkg::*;

  afc_half_div_t count_ff;
  logic phase_ff;
  afc_half_div_t len;
  afc_half_div_t last_len_ff;
  logic [3:0] age_ff;
  afc_half_div_t half_q_ff;

  // period in whole cycles; odd halves alternate floor and ceil
  always_comb begin
    len = {1'b0, div_if.half_div[6:1]} +
          {6'h0, div_if.half_div[0] & phase_ff};
  end

  assign div_if.tick = div_if.enable && (count_ff >= len);
  assign div_if.level = div_if.enable &&
                        ({count_ff, 1'b0} <= {1'b0, len});

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !div_if.enable) begin
      count_ff <= 7'h01;
      phase_ff <= 1'b0;
    end else if (div_if.tick) begin
      count_ff <= 7'h01;
      phase_ff <= ~phase_ff;
    end else begin
      count_ff <= count_ff + 7'h01;
    end
  end

  // checker helpers: last period and settings age
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !div_if.enable) begin
      last_len_ff <= 7'h00;
      age_ff <= 4'h0;
      half_q_ff <= 7'h00;
    end else begin
      half_q_ff <= div_if.half_div;
      if (half_q_ff != div_if.half_div) begin
        age_ff <= 4'h0;
      end else if (div_if.tick && age_ff != `AFC_AGE_MAX) begin
        age_ff <= age_ff + 4'h1;
      end
      if (div_if.tick) begin
        last_len_ff <= count_ff;
      end
    end
  end

  // two periods add up to the half ratio
  AST_HALF_SPLIT: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    div_if.tick && div_if.half_div[0] && age_ff > 4'h2
    |-> (count_ff + last_len_ff) == div_if.half_div)
    else $error("half ratio periods do not sum correctly");

  AST_WHOLE_PERIOD: assert property (
    @(posedge clk_in)
    disable iff (!rst_n_in)
    div_if.tick && !div_if.half_div[0] && age_ff > 4'h2
    |-> {count_ff, 1'b0} == {1'b0, div_if.half_div})
    else $error("whole ratio period is wrong");
endmodule // afc_frac_div

// ### core/afc_clock_gen.sv
// frame clock, bit clock, aux clock and slow clock generation
//
// What this block does
// - master: ADC and DAC frame clocks counted from bit clock, independent.
// - master bit clock for frame dividers comes from system clock divider.
// - slave mode: far party drives both frame clocks, device takes them in.
// - shared frame pin by default; separate ADC frame only via general pin.
// - bit 15 picks shared pin source: 0 DAC frame, 1 ADC frame.
// - bit 11 enables ADC frame generation, master when set; resets off.
// - bit 11 enables DAC frame generation, master when set; resets off.
// - 11-bit bit-clocks-per-phase count, reset 64, up to 2047.
// - general pin set as aux clock outputs divided system clock.
// - aux divide codes 1-5 give 2,3,4,5.5,6; code 0 holds aux clock low; codes 6,7 reserved.
// - slow clock runs only when enabled; feeds debounce and zero-cross.
// - rate bit 14: 0 divides by 2^21, 1 divides by 2^19.
// - slow enable is one bit seen at two register locations.
// - bits 7:4 set master bit clock divide, including half ratios.
// - bit 14 master select drives bit clock pin; else bit clock input.
`timescale 1ns/1ps
`include "afc_map.svh"
module afc_clock_gen #(
  parameter int SLOW_LOG_SLOW = `AFC_SLOW_LOG_SLOW,
  parameter int SLOW_LOG_FAST = `AFC_SLOW_LOG_FAST,
  parameter int ADDR_W = 12
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire afc_pkg::afc_word_t pwdata_in,
  output afc_pkg::afc_word_t prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic bit_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe_out,
  input wire logic frame_pin_in,
  output logic frame_pin_out,
  output logic frame_pin_oe_out,
  input wire logic adc_gpio_frame_fn_in,
  input wire logic adc_frame_pin_in,
  output logic adc_frame_pin_out,
  output logic adc_frame_pin_oe_out,
  input wire logic aux_gpio_clock_fn_in,
  output logic aux_output_clock_out,
  output logic aux_output_clock_oe_out,
  output logic adc_frame_clock_out,
  output logic dac_frame_clock_out,
  output logic slow_clock_tick_out
);
  import afc_pkg::*;

  localparam int SLOW_W = SLOW_LOG_SLOW;
  localparam logic [SLOW_W-1:0] SLOW_END_SLOW =
    SLOW_W'((64'd1 << SLOW_LOG_SLOW) - 64'd1);
  localparam logic [SLOW_W-1:0] SLOW_END_FAST =
    SLOW_W'((64'd1 << SLOW_LOG_FAST) - 64'd1);

  // control fields
  logic slow_clock_enable_ff;
  logic slow_clock_rate_select_ff;
  logic [3:0] bit_clock_divider_ff;
  logic [2:0] output_clock_divider_ff;
  logic frame_pin_source_select_ff;
  logic bit_clock_master_enable_ff;
  logic [1:0] frame_gen_enable_ff;
  afc_len_t frame_length_ff [2];

  // bus
  logic pready_ff;
  logic pslverr_ff;
  afc_word_t prdata_ff;
  logic [`AFC_IDX_W-1:0] reg_idx;
  logic wr_go;
  logic rd_hit;
  afc_word_t rd_data;

  // clocks
  logic bclk_q_ff;
  logic bclk_prev_ff;
  logic bclk_tick;
  logic [1:0] frame_ff;
  logic [1:0] frame_src;
  afc_len_t frame_cnt_ff [2];
  logic [SLOW_W-1:0] slow_cnt_ff;
  logic [SLOW_W-1:0] slow_end;
  logic aux_valid;

  afc_div_if bdiv_if ();
  afc_div_if adiv_if ();

  afc_frac_div u_bit_div (
    .clk_in (clk_in),
    .rst_n_in (rst_n_in),
    .div_if (bdiv_if.div)
  );

  afc_frac_div u_aux_div (
    .clk_in (clk_in),
    .rst_n_in (rst_n_in),
    .div_if (adiv_if.div)
  );

  // ratio in half cycles for the bit clock divider
  function automatic afc_half_div_t bclk_halves(input logic [3:0] code);
    case (code)
      4'h0: bclk_halves = 7'h02;
      4'h1: bclk_halves = 7'h03;
      4'h2: bclk_halves = 7'h04;
      4'h3: bclk_halves = 7'h06;
      4'h4: bclk_halves = 7'h08;
      4'h5: bclk_halves = 7'h0b;
      4'h6: bclk_halves = 7'h0c;
      4'h7: bclk_halves = 7'h10;
      4'h8: bclk_halves = 7'h16;
      4'h9: bclk_halves = 7'h18;
      4'ha: bclk_halves = 7'h20;
      4'hb: bclk_halves = 7'h2c;
      4'hc: bclk_halves = 7'h30;
      default: bclk_halves = 7'h40;
    endcase
  endfunction

  // ratio in half cycles for the aux output clock
  function automatic afc_half_div_t aux_halves(input logic [2:0] code);
    case (code)
      3'h0: aux_halves = 7'h02;
      3'h1: aux_halves = 7'h04;
      3'h2: aux_halves = 7'h06;
      3'h3: aux_halves = 7'h08;
      3'h4: aux_halves = 7'h0b;
      default: aux_halves = 7'h0c;
    endcase
  endfunction

  assign bdiv_if.enable = bit_clock_master_enable_ff;
  assign bdiv_if.half_div = bclk_halves(bit_clock_divider_ff);

  // reserved codes stop the aux clock
  assign aux_valid = (output_clock_divider_ff <= 3'h5);
  assign adiv_if.enable = aux_gpio_clock_fn_in && aux_valid;
  assign adiv_if.half_div = aux_halves(output_clock_divider_ff);

  // apb decode: one wait state, answer registered
  assign reg_idx = paddr_in[`AFC_IDX_W+1:2];
  assign wr_go = psel_in && penable_in && pready_ff && pwrite_in &&
                 !pslverr_ff;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (reg_idx)
      `AFC_IDX_PWR_FOUR: rd_data[`AFC_BIT_SLOW_EN_PWR] = slow_clock_enable_ff;
      `AFC_IDX_CLK_ONE: begin
        rd_data[`AFC_BIT_SLOW_EN_CLK] = slow_clock_enable_ff;
        rd_data[`AFC_BIT_SLOW_RATE] = slow_clock_rate_select_ff;
        rd_data[`AFC_BCLK_DIV_MSB:`AFC_BCLK_DIV_LSB] = bit_clock_divider_ff;
        rd_data[`AFC_OUT_DIV_MSB:0] = output_clock_divider_ff;
      end
      `AFC_IDX_CLK_TWO:
        rd_data[`AFC_BIT_FRAME_SEL] = frame_pin_source_select_ff;
      `AFC_IDX_DAC_RATE: begin
        rd_data[`AFC_BIT_FRAME_EN] = frame_gen_enable_ff[AFC_CH_DAC];
        rd_data[`AFC_LEN_MSB:0] = frame_length_ff[AFC_CH_DAC];
      end
      `AFC_IDX_ADC_RATE: begin
        rd_data[`AFC_BIT_FRAME_EN] = frame_gen_enable_ff[AFC_CH_ADC];
        rd_data[`AFC_LEN_MSB:0] = frame_length_ff[AFC_CH_ADC];
      end
      `AFC_IDX_DAC_IF:
        rd_data[`AFC_BIT_BIT_CLOCK_MASTER_ENABLE] = bit_clock_master_enable_ff;
      `AFC_IDX_STATUS: rd_data[3:0] = {bit_clock_out, slow_clock_enable_ff,
                                       frame_ff[AFC_CH_DAC],
                                       frame_ff[AFC_CH_ADC]};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (psel_in && penable_in && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= !rd_hit || (pwrite_in && reg_idx == `AFC_IDX_STATUS);
      prdata_ff <= pwrite_in ? 32'h0000_0000 : rd_data;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      slow_clock_enable_ff <= 1'b0;
    end else if (wr_go && reg_idx == `AFC_IDX_PWR_FOUR) begin
      slow_clock_enable_ff <= pwdata_in[`AFC_BIT_SLOW_EN_PWR];
    end else if (wr_go && reg_idx == `AFC_IDX_CLK_ONE) begin
      slow_clock_enable_ff <= pwdata_in[`AFC_BIT_SLOW_EN_CLK];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      slow_clock_rate_select_ff <= 1'b0;
      bit_clock_divider_ff <= `AFC_BCLK_DIV_RST;
      output_clock_divider_ff <= `AFC_OUT_DIV_RST;
      frame_pin_source_select_ff <= 1'b0;
      bit_clock_master_enable_ff <= 1'b0;
    end else if (wr_go) begin
      if (reg_idx == `AFC_IDX_CLK_ONE) begin
        slow_clock_rate_select_ff <= pwdata_in[`AFC_BIT_SLOW_RATE];
        bit_clock_divider_ff <=
          pwdata_in[`AFC_BCLK_DIV_MSB:`AFC_BCLK_DIV_LSB];
        output_clock_divider_ff <= pwdata_in[`AFC_OUT_DIV_MSB:0];
      end
      if (reg_idx == `AFC_IDX_CLK_TWO) begin
        frame_pin_source_select_ff <= pwdata_in[`AFC_BIT_FRAME_SEL];
      end
      if (reg_idx == `AFC_IDX_DAC_IF) begin
        bit_clock_master_enable_ff <= pwdata_in[`AFC_BIT_BIT_CLOCK_MASTER_ENABLE];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      frame_gen_enable_ff <= 2'b00;
      frame_length_ff[AFC_CH_ADC] <= `AFC_LEN_RST;
      frame_length_ff[AFC_CH_DAC] <= `AFC_LEN_RST;
    end else if (wr_go && reg_idx == `AFC_IDX_ADC_RATE) begin
      frame_gen_enable_ff[AFC_CH_ADC] <= pwdata_in[`AFC_BIT_FRAME_EN];
      frame_length_ff[AFC_CH_ADC] <= pwdata_in[`AFC_LEN_MSB:0];
    end else if (wr_go && reg_idx == `AFC_IDX_DAC_RATE) begin
      frame_gen_enable_ff[AFC_CH_DAC] <= pwdata_in[`AFC_BIT_FRAME_EN];
      frame_length_ff[AFC_CH_DAC] <= pwdata_in[`AFC_LEN_MSB:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bclk_q_ff <= 1'b0;
      bclk_prev_ff <= 1'b0;
    end else begin
      bclk_q_ff <= bit_clock_in;
      bclk_prev_ff <= bclk_q_ff;
    end
  end

  assign bclk_tick = bit_clock_master_enable_ff ? bdiv_if.tick :
                     (bclk_q_ff && !bclk_prev_ff);

  assign frame_src[AFC_CH_DAC] = frame_pin_in;
  assign frame_src[AFC_CH_ADC] = adc_gpio_frame_fn_in ? adc_frame_pin_in :
                                 frame_pin_in;

  for (genvar ch = 0; ch < 2; ch++) begin : g_frame
    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        frame_cnt_ff[ch] <= 11'h000;
        frame_ff[ch] <= 1'b0;
      end else if (!frame_gen_enable_ff[ch]) begin
        frame_cnt_ff[ch] <= 11'h000;
        frame_ff[ch] <= frame_src[ch];
      end else if (bclk_tick) begin
        if (frame_cnt_ff[ch] + 11'h001 >= frame_length_ff[ch]) begin
          frame_cnt_ff[ch] <= 11'h000;
          frame_ff[ch] <= ~frame_ff[ch];
        end else begin
          frame_cnt_ff[ch] <= frame_cnt_ff[ch] + 11'h001;
        end
      end
    end

    AST_PHASE_LEN: assert property (
      @(posedge clk_in)
      disable iff (!rst_n_in)
      frame_gen_enable_ff[ch] && $past(frame_gen_enable_ff[ch]) &&
      frame_ff[ch] != $past(frame_ff[ch]) &&
      $past(frame_length_ff[ch]) >= 11'h008
      |-> $past(frame_cnt_ff[ch]) + 11'h001 == $past(frame_length_ff[ch]))
      else $error("frame phase length differs from setting");

    AST_SLAVE_FOLLOW: assert property (
      @(posedge clk_in)
      disable iff (!rst_n_in)
      !frame_gen_enable_ff[ch] |=> frame_ff[ch] == $past(frame_src[ch]))
      else $error("slave frame clock does not follow its input");
  end

  assign slow_end = slow_clock_rate_select_ff ? SLOW_END_FAST : SLOW_END_SLOW;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !slow_clock_enable_ff) begin
      slow_cnt_ff <= '0;
      slow_clock_tick_out <= 1'b0;
    end else if (slow_cnt_ff >= slow_end) begin
      slow_cnt_ff <= '0;
      slow_clock_tick_out <= 1'b1;
    end else begin
      slow_cnt_ff <= slow_cnt_ff + 1'b1;
      slow_clock_tick_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bit_clock_out <= 1'b0;
      bit_clock_oe_out <= 1'b0;
      frame_pin_out <= 1'b0;
      frame_pin_oe_out <= 1'b0;
      adc_frame_pin_out <= 1'b0;
      adc_frame_pin_oe_out <= 1'b0;
      aux_output_clock_out <= 1'b0;
      aux_output_clock_oe_out <= 1'b0;
      adc_frame_clock_out <= 1'b0;
      dac_frame_clock_out <= 1'b0;
    end else begin
      bit_clock_out <= bdiv_if.level;
      bit_clock_oe_out <= bit_clock_master_enable_ff;
      frame_pin_out <= frame_pin_source_select_ff ? frame_ff[AFC_CH_ADC] :
                       frame_ff[AFC_CH_DAC];
      frame_pin_oe_out <= frame_pin_source_select_ff ?
                          frame_gen_enable_ff[AFC_CH_ADC] :
                          frame_gen_enable_ff[AFC_CH_DAC];
      adc_frame_pin_out <= frame_ff[AFC_CH_ADC];
      adc_frame_pin_oe_out <= adc_gpio_frame_fn_in &&
                              frame_gen_enable_ff[AFC_CH_ADC];
      aux_output_clock_out <= adiv_if.level;
      aux_output_clock_oe_out <= aux_gpio_clock_fn_in;
      adc_frame_clock_out <= frame_ff[AFC_CH_ADC];
      dac_frame_clock_out <= frame_ff[AFC_CH_DAC];
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;

  AST_PIN_SOURCE: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> frame_pin_out == ($past(frame_pin_source_select_ff) ?
             $past(frame_ff[AFC_CH_ADC]) : $past(frame_ff[AFC_CH_DAC])))
    else $error("shared frame pin carries the wrong source");

  // write via power register, read via clock register
  sequence s_pwr_write;
    wr_go && reg_idx == `AFC_IDX_PWR_FOUR;
  endsequence
  sequence s_clk_one_read;
    psel_in && penable_in && !pready_ff && !pwrite_in &&
    reg_idx == `AFC_IDX_CLK_ONE;
  endsequence
  AST_ALIAS_BIT: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    s_pwr_write ##3 s_clk_one_read
    |-> rd_data[`AFC_BIT_SLOW_EN_CLK] ==
        $past(pwdata_in[`AFC_BIT_SLOW_EN_PWR], 3))
    else $error("slow enable differs between its two locations");

  // disabled slow clock held at zero
  AST_SLOW_HELD: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !slow_clock_enable_ff |=> slow_cnt_ff == '0 && !slow_clock_tick_out)
    else $error("slow clock counter runs while disabled");

  AST_SLOW_RATE: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(slow_clock_tick_out) |-> $past(slow_cnt_ff) == $past(slow_end))
    else $error("slow clock tick at wrong count");

  AST_LEN_RESET: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !$past(rst_n_in) |-> frame_length_ff[AFC_CH_ADC] == `AFC_LEN_RST &&
    frame_length_ff[AFC_CH_DAC] == `AFC_LEN_RST &&
    frame_gen_enable_ff == 2'b00)
    else $error("frame settings not at reset values");

  AST_BCLK_DRIVE: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    bit_clock_master_enable_ff ##1 bit_clock_master_enable_ff
    |-> bit_clock_oe_out)
    else $error("bit clock pin not driven in master mode");

  // reserved codes give no aux clock
  AST_AUX_RESERVED: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (output_clock_divider_ff > 3'h5) [*3] |-> !aux_output_clock_out)
    else $error("aux clock runs on a reserved code");
endmodule // afc_clock_gen

// ### tb/afc_host_model.sv
// host audio port model: bit clock and frame clocks in slave mode
`timescale 1ns/1ps
module afc_host_model #(
  parameter int DAC_LEN = 8,
  parameter int ADC_LEN = 4
) (
  input wire logic clk_in,
  input wire logic run_in,
  output logic bit_clock_out,
  output logic frame_out,
  output logic adc_frame_out
);
  int ph = 0;
  int nd = 0;
  int na = 0;
  initial begin
    bit_clock_out = 1'b0;
    frame_out = 1'b0;
    adc_frame_out = 1'b0;
  end
  always @(posedge clk_in) begin
    if (!run_in) begin
      // clock still, released lines wander
      bit_clock_out <= 1'b0;
      frame_out <= ~frame_out;
      adc_frame_out <= ~adc_frame_out;
      ph <= 0;
      nd <= 0;
      na <= 0;
    end else begin
      ph <= (ph + 1) % 2;
      if (ph == 1) begin
        bit_clock_out <= ~bit_clock_out;
        if (bit_clock_out) begin
          nd <= (nd + 1) % DAC_LEN;
          na <= (na + 1) % ADC_LEN;
          if (nd == DAC_LEN - 1)
            frame_out <= ~frame_out;
          if (na == ADC_LEN - 1)
            adc_frame_out <= ~adc_frame_out;
        end
      end
    end
  end
endmodule // afc_host_model

// ### tb/testbench.sv
// self-checking bench for the frame and aux clock generator
`timescale 1ns/1ps
`include "afc_map.svh"
module testbench;
  import afc_pkg::*;
  logic clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  afc_word_t pwdata, prdata, rd;
  logic run, adc_fn, aux_fn, bck_o, bck_oe, fr_o, fr_oe, afr_o, afr_oe;
  logic aux_o, aux_oe, adc_fr, dac_fr, slow_t, h_bck, h_fr, h_afr;
  int fails, comparisons, cycles, a, b;
  wire bck_pin = bck_oe ? bck_o : h_bck;
  wire fr_pin = fr_oe ? fr_o : h_fr;
  wire afr_pin = afr_oe ? afr_o : h_afr;

  afc_clock_gen #(.SLOW_LOG_SLOW(6), .SLOW_LOG_FAST(4), .ADDR_W(12)) i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .bit_clock_in(bck_pin), .bit_clock_out(bck_o),
    .bit_clock_oe_out(bck_oe), .frame_pin_in(fr_pin), .frame_pin_out(fr_o),
    .frame_pin_oe_out(fr_oe), .adc_gpio_frame_fn_in(adc_fn),
    .adc_frame_pin_in(afr_pin), .adc_frame_pin_out(afr_o),
    .adc_frame_pin_oe_out(afr_oe), .aux_gpio_clock_fn_in(aux_fn),
    .aux_output_clock_out(aux_o), .aux_output_clock_oe_out(aux_oe),
    .adc_frame_clock_out(adc_fr), .dac_frame_clock_out(dac_fr),
    .slow_clock_tick_out(slow_t));

  afc_host_model #(.DAC_LEN(8), .ADC_LEN(4)) i_host (
    .clk_in(clk_in), .run_in(run), .bit_clock_out(h_bck),
    .frame_out(h_fr), .adc_frame_out(h_afr));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      wrap_up;
    end
  end

  task check(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [9:0] idx, input afc_word_t d);
    int k;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1);
    check("wait states", k, 2);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [9:0] idx, input afc_word_t d);
    apb(1'b1, idx, d);
  endtask

  task rdc(input string name, input logic [9:0] idx, input afc_word_t exp);
    apb(1'b0, idx, 32'h0);
    check(name, rd, exp);
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return dac_fr;
      1: return adc_fr;
      2: return aux_o;
      3: return slow_t;
      4: return fr_o;
      6: return afr_o;
      default: return bck_o;
    endcase
  endfunction

  // two consecutive rise-to-rise periods, -1 when none
  task period(input int w, output int pa, output int pb);
    int t[3];
    int n;
    int k;
    logic p;
    logic s;
    n = 0;
    p = sig(w);
    for (k = 0; k < 3000 && n < 3; k++) begin
      @(posedge clk_in);
      s = sig(w);
      if (s === 1'b1 && p === 1'b0) begin
        t[n] = k;
        n++;
      end
      p = s;
    end
    pa = (n == 3) ? t[1] - t[0] : -1;
    pb = (n == 3) ? t[2] - t[1] : -1;
  endtask

  task t_reset;
    rdc("adc rate", `AFC_IDX_ADC_RATE, 32'h40);
    rdc("dac rate", `AFC_IDX_DAC_RATE, 32'h40);
    rdc("clk one", `AFC_IDX_CLK_ONE, 32'h0);
    rdc("clk two", `AFC_IDX_CLK_TWO, 32'h0);
    rdc("pwr four", `AFC_IDX_PWR_FOUR, 32'h0);
    wr(`AFC_IDX_ADC_RATE, 32'h7ff);
    rdc("len max", `AFC_IDX_ADC_RATE, 32'h7ff);
    apb(1'b0, 10'h001, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    wr(`AFC_IDX_STATUS, 32'h0);
    check("status write err", err, 1'b1);
  endtask

  task t_slow;
    wr(`AFC_IDX_PWR_FOUR, 32'h100);
    rdc("alias on", `AFC_IDX_CLK_ONE, 32'h8000);
    period(3, a, b);
    check("slow", a, 64);
    wr(`AFC_IDX_CLK_ONE, 32'hc000);
    period(3, a, b);
    check("slow fast", a, 16);
    wr(`AFC_IDX_CLK_ONE, 32'h4000);
    rdc("alias off", `AFC_IDX_PWR_FOUR, 32'h0);
    period(3, a, b);
    check("slow off", a, 32'hffff_ffff);
    wr(`AFC_IDX_PWR_FOUR, 32'h100);
    for (a = 0; a < 100 && slow_t !== 1'b1; a++)
      @(posedge clk_in);
    check("slow restart", a >= 14 && a <= 19, 1'b1);
  endtask

  task t_master;
    wr(`AFC_IDX_DAC_IF, 32'h4000);
    wr(`AFC_IDX_DAC_RATE, 32'h808);
    repeat (4) @(posedge clk_in);
    check("bclk oe", bck_oe, 1'b1);
    check("pin oe", fr_oe, 1'b1);
    period(0, a, b);
    check("dac", a, 16);
    period(4, a, b);
    check("pin dac", a, 16);
    wr(`AFC_IDX_ADC_RATE, 32'h80c);
    wr(`AFC_IDX_CLK_TWO, 32'h8000);
    period(1, a, b);
    check("adc", a, 24);
    period(4, a, b);
    check("pin adc", a, 24);
    adc_fn <= 1'b1;
    period(6, a, b);
    check("adc pin", a, 24);
    check("adc pin oe", afr_oe, 1'b1);
    adc_fn <= 1'b0;
    wr(`AFC_IDX_CLK_ONE, 32'h20);
    period(5, a, b);
    check("bclk div2", a, 2);
    period(0, a, b);
    check("dac div2", a, 32);
    wr(`AFC_IDX_CLK_ONE, 32'h10);
    period(0, a, b);
    check("dac div1.5", a + b, 48);
  endtask

  task t_slave;
    wr(`AFC_IDX_DAC_IF, 32'h0);
    wr(`AFC_IDX_DAC_RATE, 32'h8);
    wr(`AFC_IDX_ADC_RATE, 32'hc);
    adc_fn <= 1'b1;
    run <= 1'b1;
    repeat (4) @(posedge clk_in);
    check("slave bclk oe", bck_oe, 1'b0);
    check("slave pin oe", fr_oe, 1'b0);
    check("slave adc oe", afr_oe, 1'b0);
    period(0, a, b);
    check("slave dac", a, 64);
    period(1, a, b);
    check("slave adc gpio", a, 32);
    adc_fn <= 1'b0;
    period(1, a, b);
    check("slave adc shared", a, 64);
    run <= 1'b0;
  endtask

  task t_aux;
    int sums[8] = '{0, 4, 6, 8, 11, 12, 0, 0};
    aux_fn <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(`AFC_IDX_CLK_ONE, c);
      period(2, a, b);
      if (c >= 1 && c <= 5)
        check("aux period", a + b, sums[c]);
      else
        check("aux level", aux_o, 1'b0);
      if (c == 4)
        check("aux alt", a == 5 || a == 6, 1'b1);
    end
    check("aux oe", aux_oe, 1'b1);
  endtask

  initial begin
    rst_n_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    run = 1'b0;
    adc_fn = 1'b0;
    aux_fn = 1'b0;
    fails = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset;
    t_slow;
    t_master;
    t_slave;
    t_aux;
    wrap_up;
  end
endmodule // testbench
